// ==== offcore_filter_assertions.sv ====
/* Port checker for the off-core response filter.
   Assumes the client variant and one clock; bound below. */
`timescale 1ns/100ps
module offcore_filter_assertions #(
   parameter int NUM_EVENTS = 2,
   parameter int CNT_W = 48
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic cfg_rd_i,
   input wire logic [NUM_EVENTS-1:0] count_clr_i,
   input wire offcore_filter_pkg::offcore_rsp_t rsp_i,
   input wire logic [63:0] cfg_rdata_o,
   input wire logic cfg_rvalid_o,
   input wire logic [NUM_EVENTS-1:0] match_o,
   input wire logic [NUM_EVENTS*CNT_W-1:0] count_o
);
   // ----------------------------------------------------------------
   // Port relations
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   rd_answer_a: assert property (cfg_rd_i |=> cfg_rvalid_o) else $error("read not answered");
   rd_cause_a: assert property (cfg_rvalid_o |-> $past(cfg_rd_i)) else $error("stray read valid");
   rdata_hold_a: assert property (!cfg_rvalid_o |-> $stable(cfg_rdata_o)) else $error("rdata moved");
   req_rsvd_a: assert property (cfg_rvalid_o |-> cfg_rdata_o[14:12] == 3'h0) else $error("req hole set");
   sup_rsvd_a: assert property (cfg_rvalid_o |-> !cfg_rdata_o[21] && cfg_rdata_o[30:23] == 8'h00)
      else $error("supplier hole set");
   top_zero_a: assert property (cfg_rvalid_o |-> cfg_rdata_o[63:38] == 26'h0) else $error("top bits set");
   match_cause_a: assert property (|match_o |-> $past(rsp_i.valid) && |$past(rsp_i.req))
      else $error("match without request");
   cnt_hold_a: assert property (!$past(match_o[0]) && !$past(count_clr_i[0]) |-> $stable(count_o[CNT_W-1:0]))
      else $error("count moved");
   cnt_clear_a: assert property (count_clr_i[0] |=> count_o[CNT_W-1:0] == '0) else $error("clear lost");
   cover property (cfg_rvalid_o);
   cover property (match_o[0]);
   cover property (match_o[1]);
endmodule : offcore_filter_assertions
bind offcore_response_event_filter offcore_filter_assertions #(.NUM_EVENTS(NUM_EVENTS), .CNT_W(CNT_W)) chk (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .cfg_rd_i(cfg_rd_i), .count_clr_i(count_clr_i), .rsp_i(rsp_i),
   .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .match_o(match_o), .count_o(count_o));

// ==== offcore_filter_pkg.sv ====
/*
 * Constants and types for the off-core response match filter.
 * Assumes a 64-bit configuration word per event and one core clock.
 */
package offcore_filter_pkg;

   // ----------------------------------------------------------------
   // Configuration word layout
   // ----------------------------------------------------------------
   localparam int CFG_W = 64;
   localparam int REQ_LSB = 0;
   localparam int REQ_W = 16;
   localparam int SUP_LSB = 16;
   localparam int SUP_W = 15;
   localparam int SNP_LSB = 31;
   localparam int SNP_W = 7;
   localparam int TOP_W = CFG_W - SNP_LSB - SNP_W;
   localparam logic [CFG_W-1:0] CFG_RESET = 64'h0000_0000_0000_0000;

   // ----------------------------------------------------------------
   // Request-type bit positions
   // ----------------------------------------------------------------
   localparam int demand_data_read_sel = 0;
   localparam int demand_ownership_read_sel = 1;
   localparam int demand_instruction_fetch_sel = 2;
   localparam int modified_writeback_sel = 3;
   localparam int l2_prefetch_data_sel = 4;
   localparam int l2_prefetch_ownership_sel = 5;
   localparam int l2_prefetch_code_sel = 6;
   localparam int l3_prefetch_data_sel = 7;
   localparam int l3_prefetch_ownership_sel = 8;
   localparam int l3_prefetch_code_sel = 9;
   localparam int split_or_uncached_lock_sel = 10;
   localparam int streaming_store_sel = 11;
   localparam int other_request_sel = 15;

   // ----------------------------------------------------------------
   // Supplier bit positions (absolute within the word)
   // ----------------------------------------------------------------
   localparam int any_response_sel = 16;
   localparam int no_supplier_info_sel = 17;
   localparam int l3_modified_hit_sel = 18;
   localparam int l3_exclusive_hit_sel = 19;
   localparam int l3_shared_hit_sel = 20;
   localparam int l3_forward_hit_sel = 21;
   localparam int local_dram_sel = 22;
   localparam int l4_near_hit_sel = 22;
   localparam int l4_far_hop0_sel = 23;
   localparam int l4_far_hop1_sel = 24;
   localparam int l4_far_hop2plus_sel = 25;
   localparam int far_supplier_hop0_sel = 27;
   localparam int far_supplier_hop1_sel = 28;
   localparam int far_supplier_hop2plus_sel = 29;

   // ----------------------------------------------------------------
   // Product variants
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      VARIANT_CLIENT = 3'h1,
      VARIANT_L4 = 3'h2,
      VARIANT_SERVER = 3'h4
   } variant_t;

   typedef struct packed {
      logic [TOP_W-1:0] unused;
      logic [SNP_W-1:0] snoop;
      logic [SUP_W-1:0] supplier;
      logic [REQ_W-1:0] req;
   } match_cfg_t;

   // One off-core response as reported by the uncore interface
   typedef struct packed {
      logic valid;
      logic [REQ_W-1:0] req;
      logic [SUP_W-1:0] supplier;
      logic [SNP_W-1:0] snoop;
   } offcore_rsp_t;

endpackage : offcore_filter_pkg

// ==== offcore_response_event_filter.sv ====
/*
 * Off-core response event filter: per-event match configuration words,
 * a qualifier for each off-core response, and one counter per event.
 * Assumes responses and configuration accesses come from logic on
 * sys_clk_i; software programs a word before enabling its counter.
 */
// Summary of operation
// - One configuration word per off-core event
// - Request-type mask occupies bits 15:0
// - Supplier mask occupies bits 30:16
// - Snoop-response mask occupies bits 37:31
// - Bit 0: demand data and page-walk reads
// - Bit 1: demand and prefetch ownership reads
// - Bit 2: demand and L1 instruction reads
// - Bit 3: modified line writebacks
// - Bits 4-6: second-level prefetcher requests
// - Bits 7-9: third-level prefetcher requests
// - Bit 10: split or uncacheable locks
// - Bit 11 streaming stores; 14:12 reserved
// - Bit 15: any other interface request
// - Supplier bit 16 matches any response
// - Bit 17: no supplier information
// - Bits 18-20: L3 M, E, S hits
// - Client: bit 22 local DRAM
// - L4 variant: bits 22-25 fourth-level hits
// - Server: bits 27-29 remote miss suppliers
`timescale 1ns/100ps

module offcore_response_event_filter #(
   parameter int NUM_EVENTS = 2,
   parameter int CNT_W = 48,
   parameter offcore_filter_pkg::variant_t VARIANT = offcore_filter_pkg::VARIANT_CLIENT,
   localparam int IDX_W = (NUM_EVENTS > 1) ? $clog2(NUM_EVENTS) : 1
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [IDX_W-1:0] cfg_sel_i,
   input wire logic [offcore_filter_pkg::CFG_W-1:0] cfg_wdata_i,
   input wire logic [NUM_EVENTS-1:0] count_en_i,
   input wire logic [NUM_EVENTS-1:0] count_clr_i,
   input wire offcore_filter_pkg::offcore_rsp_t rsp_i,
   output logic [offcore_filter_pkg::CFG_W-1:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   output logic [NUM_EVENTS-1:0] match_o,
   output logic [NUM_EVENTS*CNT_W-1:0] count_o
);

   // ----------------------------------------------------------------
   // Writable bits per variant
   // ----------------------------------------------------------------
   // Reserved bits are dropped on write so they always read back as
   // zero; a careless write of ones cannot widen the match.
   function automatic logic [offcore_filter_pkg::CFG_W-1:0] writable_mask(
      input offcore_filter_pkg::variant_t v
   );
      logic [offcore_filter_pkg::CFG_W-1:0] m;
      m = '0;
      m[offcore_filter_pkg::demand_data_read_sel] = 1'b1;
      m[offcore_filter_pkg::demand_ownership_read_sel] = 1'b1;
      m[offcore_filter_pkg::demand_instruction_fetch_sel] = 1'b1;
      m[offcore_filter_pkg::modified_writeback_sel] = 1'b1;
      m[offcore_filter_pkg::l2_prefetch_data_sel] = 1'b1;
      m[offcore_filter_pkg::l2_prefetch_ownership_sel] = 1'b1;
      m[offcore_filter_pkg::l2_prefetch_code_sel] = 1'b1;
      m[offcore_filter_pkg::l3_prefetch_data_sel] = 1'b1;
      m[offcore_filter_pkg::l3_prefetch_ownership_sel] = 1'b1;
      m[offcore_filter_pkg::l3_prefetch_code_sel] = 1'b1;
      m[offcore_filter_pkg::split_or_uncached_lock_sel] = 1'b1;
      m[offcore_filter_pkg::streaming_store_sel] = 1'b1;
      m[offcore_filter_pkg::other_request_sel] = 1'b1;
      m[offcore_filter_pkg::any_response_sel] = 1'b1;
      m[offcore_filter_pkg::no_supplier_info_sel] = 1'b1;
      m[offcore_filter_pkg::l3_modified_hit_sel] = 1'b1;
      m[offcore_filter_pkg::l3_exclusive_hit_sel] = 1'b1;
      m[offcore_filter_pkg::l3_shared_hit_sel] = 1'b1;
      m[offcore_filter_pkg::SNP_LSB +: offcore_filter_pkg::SNP_W] = '1;
      case (v)
         offcore_filter_pkg::VARIANT_CLIENT: begin
            m[offcore_filter_pkg::local_dram_sel] = 1'b1;
         end
         offcore_filter_pkg::VARIANT_L4: begin
            m[offcore_filter_pkg::l4_near_hit_sel] = 1'b1;
            m[offcore_filter_pkg::l4_far_hop0_sel] = 1'b1;
            m[offcore_filter_pkg::l4_far_hop1_sel] = 1'b1;
            m[offcore_filter_pkg::l4_far_hop2plus_sel] = 1'b1;
         end
         offcore_filter_pkg::VARIANT_SERVER: begin
            m[offcore_filter_pkg::l3_forward_hit_sel] = 1'b1;
            m[offcore_filter_pkg::local_dram_sel] = 1'b1;
            m[offcore_filter_pkg::far_supplier_hop0_sel] = 1'b1;
            m[offcore_filter_pkg::far_supplier_hop1_sel] = 1'b1;
            m[offcore_filter_pkg::far_supplier_hop2plus_sel] = 1'b1;
         end
         default: begin
            m = m;
         end
      endcase
      return m;
   endfunction : writable_mask

   // ----------------------------------------------------------------
   // Match qualifier
   // ----------------------------------------------------------------
   function automatic logic rsp_matches(
      input offcore_filter_pkg::match_cfg_t c,
      input offcore_filter_pkg::offcore_rsp_t r
   );
      logic req_hit;
      logic rsp_hit;
      logic any_hit;
      req_hit = |(c.req & r.req);
      any_hit = c.supplier[offcore_filter_pkg::any_response_sel - offcore_filter_pkg::SUP_LSB];
      rsp_hit = any_hit | (|(c.supplier & r.supplier)) | (|(c.snoop & r.snoop));
      return r.valid & req_hit & rsp_hit;
   endfunction : rsp_matches

   localparam logic [offcore_filter_pkg::CFG_W-1:0] WR_MASK = writable_mask(VARIANT);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      offcore_filter_pkg::match_cfg_t [NUM_EVENTS-1:0] cfg;
      logic [NUM_EVENTS-1:0][CNT_W-1:0] count;
      logic [NUM_EVENTS-1:0] match;
      logic [offcore_filter_pkg::CFG_W-1:0] rdata;
      logic rvalid;
   } filter_state_t;

   filter_state_t state_ff;
   filter_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      nxt_state.rvalid = cfg_rd_i;
      if (cfg_rd_i) begin
         nxt_state.rdata = state_ff.cfg[cfg_sel_i];
      end
      if (cfg_wr_i) begin
         nxt_state.cfg[cfg_sel_i] = cfg_wdata_i & WR_MASK;
      end
      for (int e = 0; e < NUM_EVENTS; e++) begin
         // Each event qualifies against its own word only
         nxt_state.match[e] = count_en_i[e] & rsp_matches(state_ff.cfg[e], rsp_i);
         if (count_clr_i[e]) begin
            nxt_state.count[e] = '0;
         end else if (state_ff.match[e]) begin
            nxt_state.count[e] = state_ff.count[e] + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign cfg_rdata_o = state_ff.rdata;
   assign cfg_rvalid_o = state_ff.rvalid;
   assign match_o = state_ff.match;
   assign count_o = state_ff.count;

endmodule : offcore_response_event_filter

// ==== offcore_response_event_filter_tb.sv ====
/* Self-checking bench for the off-core response filter.
   Assumes the client variant, two events and 48-bit counters. */
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module offcore_response_event_filter_tb;
   // Only these bits hold on the client variant
   localparam logic [63:0] WMASK = 64'h0000_003F_805F_8FFF;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic cfg_wr_i = 1'b0;
   logic cfg_rd_i = 1'b0;
   logic [0:0] cfg_sel_i = 1'h0;
   logic [63:0] cfg_wdata_i = 64'h0;
   logic [1:0] count_en_i = 2'h3;
   logic [1:0] count_clr_i = 2'h0;
   offcore_filter_pkg::offcore_rsp_t rsp_i = '0;
   offcore_filter_pkg::offcore_rsp_t p;
   logic [63:0] cfg_rdata_o, exp_d, x;
   logic cfg_rvalid_o, seen = 1'b0, track = 1'b1;
   logic [1:0] match_o, exp_m;
   logic [95:0] count_o;
   logic [63:0] sh [2] = '{default: '0};
   logic [47:0] cnt [2] = '{default: '0};
   logic [63:0] rq [$];
   logic [1:0] mq [$];
   int n_fail = 0;
   int total_checks = 0;
   int seed = 32'h0BDE;
   always #20 sys_clk_i = ~sys_clk_i;
   offcore_response_event_filter dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cfg_wr_i(cfg_wr_i),
      .cfg_rd_i(cfg_rd_i), .cfg_sel_i(cfg_sel_i), .cfg_wdata_i(cfg_wdata_i), .count_en_i(count_en_i),
      .count_clr_i(count_clr_i), .rsp_i(rsp_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
      .match_o(match_o), .count_o(count_o));
   function automatic logic hit(logic [63:0] c, offcore_filter_pkg::offcore_rsp_t r);
      return r.valid & (|(r.req & c[15:0])) & (c[16] | (|(r.supplier & c[30:16])) | (|(r.snoop & c[37:31])));
   endfunction : hit
   // ----------------------------------------------------------------
   // Driver: expectations use the words as they stood before this edge
   // ----------------------------------------------------------------
   task automatic drive(input logic w, input logic r, input logic s, input logic [63:0] d,
         input offcore_filter_pkg::offcore_rsp_t q);
      @(negedge sys_clk_i);
      cfg_wr_i = w;
      cfg_rd_i = r;
      cfg_sel_i = s;
      cfg_wdata_i = d;
      rsp_i = q;
      if (r) rq.push_back(sh[s]);
      if (q.valid && track) mq.push_back({hit(sh[1], q), hit(sh[0], q)});
      if (q.valid && track) for (int e = 0; e < 2; e++) cnt[e] += 48'(hit(sh[e], q) & count_en_i[e]);
      if (w) sh[s] = d & WMASK;
   endtask : drive
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   // ----------------------------------------------------------------
   // Monitor
   // ----------------------------------------------------------------
   always @(posedge sys_clk_i) seen <= rsp_i.valid & track;
   always @(negedge sys_clk_i) begin
      if (cfg_rvalid_o) begin
         exp_d = rq.pop_front();
         `CHK(cfg_rdata_o, exp_d)
      end
      if (seen) begin
         exp_m = mq.pop_front();
         `CHK(match_o, exp_m)
      end else if (!track) begin
         `CHK(match_o, 2'h0)
      end
   end
   initial begin
      repeat (5) @(negedge sys_clk_i);
      reset_i = 1'b0;
      drive(1'b0, 1'b1, 1'b0, 64'h0, '0);
      drive(1'b1, 1'b1, 1'b1, '1, '0);
      drive(1'b1, 1'b1, 1'b0, '1, '0);
      for (int i = 0; i < 38; i++) begin
         x = 64'h1 << i;
         drive(1'b1, 1'b0, 1'b0, x | (i < 16 ? 64'h1_0000 : 64'h1), '0);
         drive(1'b0, 1'b1, 1'b0, 64'h0, {1'b1, (i < 16 ? x[15:0] : 16'h1), x[30:16], x[37:31]});
      end
      for (int i = 0; i < 200; i++) begin
         x = {$random(seed), $random(seed)};
         p = x[38:0];
         drive(i % 8 == 0, i % 5 == 0, x[40], {x[31:0], x[63:32]}, p);
      end
      repeat (4) drive(1'b0, 1'b0, 1'b0, 64'h0, '0);
      `CHK(count_o, {cnt[1], cnt[0]})
      count_clr_i = 2'h1;
      cnt[0] = '0;
      drive(1'b0, 1'b0, 1'b0, 64'h0, '0);
      count_clr_i = 2'h0;
      count_en_i = 2'h0;
      track = 1'b0;
      repeat (20) drive(1'b0, 1'b0, 1'b0, 64'h0, {1'b1, 38'h3F_FFFF_FFFF});
      repeat (4) drive(1'b0, 1'b0, 1'b0, 64'h0, '0);
      `CHK(count_o, {cnt[1], cnt[0]})
      end_sim();
   end
   initial begin
      #(40 * 4000);
      n_fail++;
      end_sim();
   end
endmodule : offcore_response_event_filter_tb
